// [verilog/icf_defines.svh]
// Register offsets, field positions, reset values and vectors of the block
`ifndef ICF_DEFINES_SVH
`define ICF_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ICF_OFS_MAIN 8'h00
`define ICF_OFS_EDGE 8'h04
`define ICF_OFS_EXT 8'h08
`define ICF_OFS_PIR 8'h0C
`define ICF_OFS_PRIO 8'h10

// ==========================================================
// Reset values
`define ICF_RST_MAIN 8'h00
`define ICF_RST_EDGE 8'hF5
`define ICF_RST_EXT 8'hC0
`define ICF_RST_PIR 8'h00

// ==========================================================
// Writable bit masks; zero bits are unimplemented or read-only
`define ICF_MASK_EDGE 8'hF5
`define ICF_MASK_EXT 8'hDB

// ==========================================================
// Main control register fields
`define ICF_B_GEN_HIGH 7
`define ICF_B_GEN_LOW 6
`define ICF_B_T0EN 5
`define ICF_B_X0EN 4
`define ICF_B_PCEN 3
`define ICF_B_T0FL 2
`define ICF_B_X0FL 1
`define ICF_B_PCFL 0

// ==========================================================
// Edge and priority register fields
`define ICF_B_PUDIS 7
`define ICF_B_EDGE0 6
`define ICF_B_EDGE1 5
`define ICF_B_EDGE2 4
`define ICF_B_T0PR 2
`define ICF_B_PCPR 0

// ==========================================================
// External pin register fields
`define ICF_B_X2PR 7
`define ICF_B_X1PR 6
`define ICF_B_X2EN 4
`define ICF_B_X1EN 3
`define ICF_B_X2FL 1
`define ICF_B_X1FL 0

// ==========================================================
// Priority enable field and vectors
`define ICF_B_PRIO_ON 7
`define ICF_VEC_HIGH 16'h0008
`define ICF_VEC_LOW 16'h0018

`endif

// [verilog/icf_pkg.sv]
// Types shared by the interrupt control and flag register block
package icf_pkg;

	// ==========================================================
	// Bus slave phases
	typedef enum logic [0:0] {
		ICF_BUS_IDLE = 1'b0,
		ICF_BUS_DATA = 1'b1
	} icf_bus_e;

	typedef logic [7:0] icf_byte_t;

endpackage

// [verilog/icf_regs.sv]
// Interrupt control, edge, priority and peripheral flag registers on AHB-Lite
//
// Contract
// - Flags set regardless of any enable
// - Compat mode: bit 7 gates all interrupts
// - Priority mode: bit 7 enables high, blocks all
// - Compat mode: bit 6 gates peripheral interrupts
// - Priority mode: bit 6 enables low priority
// - Timer-0 overflow enable bit 5, flag 2
// - Pin 0 enable bit 4, flag bit 1
// - Port-B upper nibble change sets flag 0
// - Mismatch keeps setting flag; port read ends it
// - Second register bit 7 disables pull-ups
// - Edge bits 6,5,4 pick pin edges
// - Timer-0 and port-change priority bits
// - Unimplemented bits read zero, ignore writes
// - Third register bits 7,6 pin priorities
// - Third register bits 4,3 pin enables
// - Third register bits 1,0 sticky pin flags
// - Parallel port access flag; absent on small package
// - Conversion and sync serial done flags sticky
// - Receive full flag mirrors buffer, read-only
// - Transmit empty flag mirrors buffer, read-only
// - Capture/compare flag, unused in pulse-width mode
// - Timer-2 match and timer-1 overflow flags
// - Priority bits act only with scheme enabled
// - Vector 0008h high, 0018h low
// - Accept clears enable; return sets it again
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "icf_defines.svh"

module icf_regs import icf_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Event pulses and levels from peripherals
	input wire logic tmr0Overflow,
	input wire logic adcDone,
	input wire logic syncSerialDone,
	input wire logic ccpEvent,
	input wire logic ccpPwmMode,
	input wire logic tmr2Match,
	input wire logic tmr1Overflow,
	input wire logic pspAccess,
	input wire logic serialRxFull,
	input wire logic serialTxEmpty,
	input wire logic [7:0] periphEnable,
	input wire logic [7:0] periphPriority,
	// Pins
	input wire logic [2:0] extPin,
	input wire logic [3:0] portBHigh,
	input wire logic smallPackage,
	// Core handshake
	input wire logic portBRead,
	input wire logic irqAck,
	input wire logic irqReturn,
	output logic irqReq,
	output logic [15:0] irqVector,
	output logic portPullupDisable
);

	// ==========================================================
	// Flag update: a hardware set wins over a software write
	function automatic logic nextFlag(input logic cur, input logic set,
		input logic we, input logic wbit);
		nextFlag = set | (we ? wbit : cur);
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [2:0] extS1_q, extS2_q, extS3_q;
	logic [3:0] pbS1_q, pbS2_q;
	logic smallS1_q, smallS2_q;

	// Third stage of the pin path only feeds the edge detector
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			extS1_q <= 3'h0;
			extS2_q <= 3'h0;
			extS3_q <= 3'h0;
			pbS1_q <= 4'h0;
			pbS2_q <= 4'h0;
			smallS1_q <= 1'b0;
			smallS2_q <= 1'b0;
		end else begin
			extS1_q <= extPin;
			extS2_q <= extS1_q;
			extS3_q <= extS2_q;
			pbS1_q <= portBHigh;
			pbS2_q <= pbS1_q;
			smallS1_q <= smallPackage;
			smallS2_q <= smallS1_q;
		end
	end

	// ==========================================================
	// Register state
	icf_byte_t main_q, edge_q, ext_q, pir_q;
	icf_byte_t main_d, edge_d, ext_d, pir_d;
	logic prioOn_q, prioOn_d;
	logic [3:0] pbLatch_q;
	logic highActive_q, highActive_d;
	icf_bus_e busState_q;
	logic [7:0] addr_q;
	logic write_q;

	// ==========================================================
	// Bus decode
	wire busAccept = hsel & htrans[1] & hready;
	wire busDo = (busState_q == ICF_BUS_DATA);
	wire busWr = busDo & write_q;
	wire [7:0] wdata = hwdata[7:0];
	wire weMain = busWr & (addr_q == `ICF_OFS_MAIN);
	wire weEdge = busWr & (addr_q == `ICF_OFS_EDGE);
	wire weExt = busWr & (addr_q == `ICF_OFS_EXT);
	wire wePir = busWr & (addr_q == `ICF_OFS_PIR);
	wire wePrio = busWr & (addr_q == `ICF_OFS_PRIO);

	// Unmapped offsets read zero and drop writes
	wire [7:0] rdByte =
		(addr_q == `ICF_OFS_MAIN) ? main_q :
		(addr_q == `ICF_OFS_EDGE) ? edge_q :
		(addr_q == `ICF_OFS_EXT) ? ext_q :
		(addr_q == `ICF_OFS_PIR) ? pir_q :
		(addr_q == `ICF_OFS_PRIO) ? {prioOn_q, 7'h00} : 8'h00;

	// ==========================================================
	// Events
	// Edge select: one picks rising, zero picks falling
	wire [2:0] edgeSel = {edge_q[`ICF_B_EDGE2], edge_q[`ICF_B_EDGE1],
		edge_q[`ICF_B_EDGE0]};
	wire [2:0] extRise = extS2_q & ~extS3_q;
	wire [2:0] extFall = ~extS2_q & extS3_q;
	wire [2:0] extEvent = (edgeSel & extRise) | (~edgeSel & extFall);
	// Pins against the value caught on the last port read
	wire portMismatch = (pbS2_q != pbLatch_q);
	wire pspSet = pspAccess & ~smallS2_q;
	wire ccpSet = ccpEvent & ~ccpPwmMode;

	// ==========================================================
	// Pending sources, split by priority
	wire t0Pend = main_q[`ICF_B_T0EN] & main_q[`ICF_B_T0FL];
	wire x0Pend = main_q[`ICF_B_X0EN] & main_q[`ICF_B_X0FL];
	wire pcPend = main_q[`ICF_B_PCEN] & main_q[`ICF_B_PCFL];
	wire x1Pend = ext_q[`ICF_B_X1EN] & ext_q[`ICF_B_X1FL];
	wire x2Pend = ext_q[`ICF_B_X2EN] & ext_q[`ICF_B_X2FL];
	wire [7:0] perPend = pir_q & periphEnable;
	wire anyCore = t0Pend | x0Pend | pcPend | x1Pend | x2Pend;
	wire anyPer = |perPend;
	// Pin 0 has no priority bit and is always high
	wire hiPend = (t0Pend & edge_q[`ICF_B_T0PR]) | x0Pend |
		(pcPend & edge_q[`ICF_B_PCPR]) | (x1Pend & ext_q[`ICF_B_X1PR]) |
		(x2Pend & ext_q[`ICF_B_X2PR]) | |(perPend & periphPriority);
	wire loPend = (t0Pend & ~edge_q[`ICF_B_T0PR]) |
		(pcPend & ~edge_q[`ICF_B_PCPR]) | (x1Pend & ~ext_q[`ICF_B_X1PR]) |
		(x2Pend & ~ext_q[`ICF_B_X2PR]) | |(perPend & ~periphPriority);
	wire globalHighEn = main_q[`ICF_B_GEN_HIGH];
	wire periphLowEn = main_q[`ICF_B_GEN_LOW];

	// ==========================================================
	// Request decision
	// Compatible mode ignores every priority bit
	wire compatReq = globalHighEn &
		(anyCore | (periphLowEn & anyPer));
	wire prioHigh = globalHighEn & hiPend;
	// Low waits while a high handler runs
	wire prioLow = globalHighEn & periphLowEn & loPend &
		~highActive_q;
	wire reqAny = prioOn_q ? (prioHigh | prioLow) : compatReq;
	wire reqIsHigh = ~prioOn_q | prioHigh;
	wire [15:0] vecSel = reqIsHigh ? `ICF_VEC_HIGH : `ICF_VEC_LOW;

	// ==========================================================
	// Accept and return
	wire ackValid = irqAck & irqReq;
	wire ackHigh = ackValid & (irqVector == `ICF_VEC_HIGH);
	wire ackLow = ackValid & (irqVector == `ICF_VEC_LOW);
	// In compatible mode every accept is high and clears bit 7
	wire retHigh = irqReturn & (~prioOn_q | highActive_q);
	wire retLow = irqReturn & prioOn_q & ~highActive_q;

	// ==========================================================
	// Main control register next value
	wire [7:0] mainWr = weMain ? wdata : main_q;
	always_comb begin
		main_d = mainWr;
		// Accept clears the admitting enable; return sets it
		if (ackHigh) begin
			main_d[`ICF_B_GEN_HIGH] = 1'b0;
		end else if (retHigh) begin
			main_d[`ICF_B_GEN_HIGH] = 1'b1;
		end
		if (ackLow) begin
			main_d[`ICF_B_GEN_LOW] = 1'b0;
		end else if (retLow) begin
			main_d[`ICF_B_GEN_LOW] = 1'b1;
		end
		main_d[`ICF_B_T0FL] = nextFlag(main_q[`ICF_B_T0FL], tmr0Overflow,
			weMain, wdata[`ICF_B_T0FL]);
		main_d[`ICF_B_X0FL] = nextFlag(main_q[`ICF_B_X0FL], extEvent[0],
			weMain, wdata[`ICF_B_X0FL]);
		main_d[`ICF_B_PCFL] = nextFlag(main_q[`ICF_B_PCFL], portMismatch,
			weMain, wdata[`ICF_B_PCFL]);
	end

	// ==========================================================
	// Edge, external pin and peripheral flag next values
	always_comb begin
		// Unimplemented bits masked out on every write
		edge_d = weEdge ? (wdata & `ICF_MASK_EDGE) : edge_q;
		ext_d = weExt ? (wdata & `ICF_MASK_EXT) : ext_q;
		ext_d[`ICF_B_X2FL] = nextFlag(ext_q[`ICF_B_X2FL], extEvent[2],
			weExt, wdata[`ICF_B_X2FL]);
		ext_d[`ICF_B_X1FL] = nextFlag(ext_q[`ICF_B_X1FL], extEvent[1],
			weExt, wdata[`ICF_B_X1FL]);
		pir_d[7] = nextFlag(pir_q[7], pspSet, wePir, wdata[7]) &
			~smallS2_q;
		pir_d[6] = nextFlag(pir_q[6], adcDone, wePir, wdata[6]);
		// Receive and transmit flags only mirror the serial unit
		pir_d[5] = serialRxFull;
		pir_d[4] = serialTxEmpty;
		pir_d[3] = nextFlag(pir_q[3], syncSerialDone, wePir, wdata[3]);
		pir_d[2] = nextFlag(pir_q[2], ccpSet, wePir, wdata[2]);
		pir_d[1] = nextFlag(pir_q[1], tmr2Match, wePir, wdata[1]);
		pir_d[0] = nextFlag(pir_q[0], tmr1Overflow, wePir, wdata[0]);
		prioOn_d = wePrio ? wdata[`ICF_B_PRIO_ON] : prioOn_q;
		highActive_d = highActive_q;
		if (ackHigh & prioOn_q) begin
			highActive_d = 1'b1;
		end else if (retHigh) begin
			highActive_d = 1'b0;
		end
	end

	// ==========================================================
	// Register file
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_q <= `ICF_RST_MAIN;
			edge_q <= `ICF_RST_EDGE;
			ext_q <= `ICF_RST_EXT;
			pir_q <= `ICF_RST_PIR;
			prioOn_q <= 1'b0;
			highActive_q <= 1'b0;
		end else begin
			main_q <= main_d;
			edge_q <= edge_d;
			ext_q <= ext_d;
			pir_q <= pir_d;
			prioOn_q <= prioOn_d;
			highActive_q <= highActive_d;
		end
	end

	// ==========================================================
	// Port latch: a read of the port ends the mismatch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pbLatch_q <= 4'h0;
		end else if (portBRead) begin
			pbLatch_q <= pbS2_q;
		end
	end

	// ==========================================================
	// Core request outputs; dropped on accept so it is not taken twice
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irqReq <= 1'b0;
			irqVector <= `ICF_VEC_HIGH;
			portPullupDisable <= 1'b1;
		end else begin
			irqReq <= reqAny & ~ackValid;
			irqVector <= vecSel;
			portPullupDisable <= edge_d[`ICF_B_PUDIS];
		end
	end

	// ==========================================================
	// Bus slave: one wait state buys a registered read path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busState_q <= ICF_BUS_IDLE;
			addr_q <= 8'h00;
			write_q <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (busDo) begin
			busState_q <= ICF_BUS_IDLE;
			hreadyout <= 1'b1;
			hrdata <= {24'h00_0000, rdByte};
		end else if (busAccept) begin
			busState_q <= ICF_BUS_DATA;
			addr_q <= haddr[7:0];
			write_q <= hwrite;
			hreadyout <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence sTake;
		busAccept && busState_q == ICF_BUS_IDLE;
	endsequence
	sequence sAnswer;
		!hreadyout ##1 hreadyout;
	endsequence

	a_bus_one_wait: assert property (sTake |=> sAnswer)
		else $error("Bus answer not after exactly one wait state");

	a_set_beats_clear: assert property (
		tmr0Overflow && weMain && !wdata[`ICF_B_T0FL]
		|=> main_q[`ICF_B_T0FL])
		else $error("Timer-0 flag lost to a same-cycle clear");

	a_flag_no_enable: assert property (
		tmr1Overflow && !globalHighEn |=> pir_q[0])
		else $error("Flag did not set with interrupts masked");

	a_t0_flag_sticky: assert property (
		main_q[`ICF_B_T0FL] && !weMain |=> main_q[`ICF_B_T0FL])
		else $error("Timer-0 flag cleared without software");

	a_pin_edge_flag: assert property (
		$rose(extS2_q[0]) && edge_q[`ICF_B_EDGE0] && !weMain
		|=> main_q[`ICF_B_X0FL])
		else $error("Rising edge on pin 0 not flagged");

	a_pin_wrong_edge: assert property (
		$fell(extS2_q[1]) && ext_d[`ICF_B_X1FL] == 1'b0 |-> edgeSel[1])
		else $error("Falling edge ignored with falling edge selected");

	a_mismatch_sets: assert property (
		portMismatch ##1 portMismatch |-> main_q[`ICF_B_PCFL])
		else $error("Port change flag not held by mismatch");

	a_unimpl_zero: assert property (
		edge_q[3] == 1'b0 && edge_q[1] == 1'b0 &&
		ext_q[5] == 1'b0 && ext_q[2] == 1'b0)
		else $error("Unimplemented bit reads one");

	a_gate_blocks_all: assert property (
		!globalHighEn ##1 !globalHighEn |-> !irqReq)
		else $error("Request raised with bit 7 clear");

	a_periph_gate: assert property (
		!prioOn_q && !periphLowEn && !anyCore |=> !irqReq)
		else $error("Peripheral request passed a closed gate");

	a_low_vector: assert property (
		prioOn_q && prioLow && !prioHigh && !ackValid
		|=> irqReq && irqVector == `ICF_VEC_LOW)
		else $error("Low request not vectored low");

	a_ack_clears: assert property (
		ackHigh && !irqReturn |=> !globalHighEn ##1 !irqReq)
		else $error("Accept did not close the global enable");

	a_small_psp: assert property (smallS2_q |=> !pir_q[7])
		else $error("Parallel port flag set on small package");

	a_rx_mirror: assert property (
		##1 pir_q[5] == $past(serialRxFull))
		else $error("Receive flag does not follow the buffer");

endmodule
`default_nettype wire

// [tb/icf_core_model.sv]
// Core model that accepts interrupt requests and returns from the handler
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Core model
module icf_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Request from the block
	input wire logic irqReq,
	input wire logic [15:0] irqVector,
	input wire logic slow,
	// Handshake back to the block
	output logic irqAck,
	output logic irqReturn,
	// Observation for the bench
	output var int acks,
	output var logic [15:0] lastVec
);
	int waitQ;
	int busyQ;

	// Ack once per request, run the handler, then return; a slow core
	// waits four cycles before accepting so the request must stand
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irqAck <= 1'b0;
			irqReturn <= 1'b0;
			acks <= 0;
			lastVec <= 16'h0000;
			waitQ <= 0;
			busyQ <= 0;
		end else begin
			irqAck <= 1'b0;
			irqReturn <= 1'b0;
			if (busyQ > 0) begin
				busyQ <= busyQ - 1;
				if (busyQ == 1) begin
					irqReturn <= 1'b1;
				end
			end else if (irqReq && !irqAck) begin
				if (waitQ < (slow ? 4 : 0)) begin
					waitQ <= waitQ + 1;
				end else begin
					irqAck <= 1'b1;
					acks <= acks + 1;
					lastVec <= irqVector;
					waitQ <= 0;
					busyQ <= 20;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the interrupt control and flag registers
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Bench top
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [7:0] ev = 8'h00;
	logic pwm = 1'b0;
	logic smallPkg = 1'b0;
	logic [7:0] perEn = 8'h00;
	logic rxFull = 1'b0;
	logic txEmpty = 1'b0;
	logic slow = 1'b0;
	logic portBRead = 1'b0;
	logic [2:0] extPin = 3'b000;
	logic [3:0] portB = 4'h0;
	wire [31:0] hrdata;
	wire hready;
	wire hresp;
	wire irqAck;
	wire irqReturn;
	wire irqReq;
	wire pud;
	wire [15:0] vec;
	int acks;
	logic [15:0] lastVec;
	int n_fail = 0;
	int checked = 0;

	always #20 clk = ~clk;

	// Event bits sit at their flag positions; bit 4 carries timer 0
	icf_regs uut (.clk(clk), .reset_n(reset_n), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.tmr0Overflow(ev[4]), .adcDone(ev[6]),
		.syncSerialDone(ev[3]), .ccpEvent(ev[2]), .ccpPwmMode(pwm),
		.tmr2Match(ev[1]), .tmr1Overflow(ev[0]), .pspAccess(ev[7]),
		.serialRxFull(rxFull), .serialTxEmpty(txEmpty),
		.periphEnable(perEn), .periphPriority(8'h00),
		.extPin(extPin), .portBHigh(portB), .smallPackage(smallPkg),
		.portBRead(portBRead), .irqAck(irqAck), .irqReturn(irqReturn),
		.irqReq(irqReq), .irqVector(vec), .portPullupDisable(pud));

	icf_core_model core (.clk(clk), .reset_n(reset_n), .irqReq(irqReq),
		.irqVector(vec), .slow(slow), .irqAck(irqAck),
		.irqReturn(irqReturn), .acks(acks), .lastVec(lastVec));

	// ==========================================================
	// Shared tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Wait for hready high at a rising edge, bounded
	task automatic waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			stop_test();
		end
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0000_0000, rd);
		chk(rd, exp);
	endtask

	task automatic pulse(input logic [7:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
		@(posedge clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rdck(8'h00, 32'h0000_0000);
		chk(hresp, 32'h0000_0000);
		rdck(8'h04, 32'h0000_00F5);
		rdck(8'h08, 32'h0000_00C0);
		rdck(8'h0C, 32'h0000_0000);
		rdck(8'h14, 32'h0000_0000);
		chk(pud, 1'b1);
		wr(8'h04, 32'h0000_00FF);
		rdck(8'h04, 32'h0000_00F5);
		wr(8'h08, 32'h0000_00FF);
		rdck(8'h08, 32'h0000_00DB);
		wr(8'h08, 32'h0000_0000);
		wr(8'h04, 32'h0000_0071);
		rdck(8'h04, 32'h0000_0071);
		chk(pud, 1'b0);
	endtask

	// Enables stay off: flags must still set
	task automatic t_periph;
		pulse(8'hCF);
		rdck(8'h0C, 32'h0000_00CF);
		wr(8'h0C, 32'h0000_0000);
		rdck(8'h0C, 32'h0000_0000);
		pwm <= 1'b1;
		smallPkg <= 1'b1;
		cyc(4);
		pulse(8'hCF);
		rdck(8'h0C, 32'h0000_004B);
		rxFull <= 1'b1;
		txEmpty <= 1'b1;
		cyc(3);
		wr(8'h0C, 32'h0000_0000);
		rdck(8'h0C, 32'h0000_0030);
		rxFull <= 1'b0;
		txEmpty <= 1'b0;
		pwm <= 1'b0;
		smallPkg <= 1'b0;
		cyc(3);
		rdck(8'h0C, 32'h0000_0000);
	endtask

	// Software clears the flag while the handler runs
	task automatic t_compat;
		wr(8'h00, 32'h0000_0020);
		pulse(8'h10);
		cyc(8);
		chk(acks, 0);
		rdck(8'h00, 32'h0000_0024);
		wr(8'h00, 32'h0000_00A4);
		cyc(6);
		chk(acks, 1);
		chk(lastVec, 32'h0000_0008);
		rdck(8'h00, 32'h0000_0024);
		wr(8'h00, 32'h0000_0020);
		cyc(20);
		rdck(8'h00, 32'h0000_00A0);
		chk(acks, 1);
		wr(8'h00, 32'h0000_0000);
	endtask

	// Timer 0 set to low priority; slow core acceptance
	task automatic t_prio;
		wr(8'h10, 32'h0000_0080);
		slow <= 1'b1;
		wr(8'h00, 32'h0000_00E0);
		pulse(8'h10);
		cyc(10);
		chk(acks, 2);
		chk(lastVec, 32'h0000_0018);
		rdck(8'h00, 32'h0000_00A4);
		wr(8'h00, 32'h0000_00A0);
		cyc(22);
		rdck(8'h00, 32'h0000_00E0);
		wr(8'h00, 32'h0000_0000);
		wr(8'h10, 32'h0000_0000);
		slow <= 1'b0;
	endtask

	task automatic t_pins;
		extPin[0] <= 1'b1;
		cyc(6);
		rdck(8'h00, 32'h0000_0002);
		wr(8'h04, 32'h0000_0051);
		extPin[1] <= 1'b1;
		cyc(6);
		rdck(8'h08, 32'h0000_0000);
		extPin[1] <= 1'b0;
		extPin[2] <= 1'b1;
		cyc(6);
		rdck(8'h08, 32'h0000_0003);
		wr(8'h08, 32'h0000_0000);
		rdck(8'h08, 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		rdck(8'h00, 32'h0000_0000);
		// Rising selected on pin 1: its fall must not flag
		wr(8'h04, 32'h0000_0071);
		extPin[1] <= 1'b1;
		cyc(6);
		rdck(8'h08, 32'h0000_0001);
		wr(8'h08, 32'h0000_0000);
		extPin[1] <= 1'b0;
		cyc(6);
		rdck(8'h08, 32'h0000_0000);
	endtask

	// Flag keeps setting until the port is read
	task automatic t_port;
		portB <= 4'h5;
		cyc(6);
		rdck(8'h00, 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		rdck(8'h00, 32'h0000_0001);
		portBRead <= 1'b1;
		@(posedge clk);
		portBRead <= 1'b0;
		cyc(3);
		wr(8'h00, 32'h0000_0000);
		rdck(8'h00, 32'h0000_0000);
	endtask

	// Peripheral source passes only with the bit 6 gate open
	task automatic t_gate;
		perEn <= 8'h01;
		pulse(8'h01);
		wr(8'h00, 32'h0000_0080);
		cyc(6);
		chk(acks, 2);
		wr(8'h00, 32'h0000_00C0);
		cyc(6);
		chk(acks, 3);
		chk(lastVec, 32'h0000_0008);
		wr(8'h0C, 32'h0000_0000);
		cyc(22);
		rdck(8'h00, 32'h0000_00C0);
		wr(8'h00, 32'h0000_0000);
		perEn <= 8'h00;
	endtask

	// Timer-0 overflow stands on the edge of a clearing write
	task automatic t_race;
		htrans <= 2'b10;
		haddr <= 32'h0000_0000;
		hwrite <= 1'b1;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= 32'h0000_0000;
		ev <= 8'h10;
		waitRdy();
		ev <= 8'h00;
		rdck(8'h00, 32'h0000_0004);
		wr(8'h00, 32'h0000_0000);
		rdck(8'h00, 32'h0000_0000);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_periph();
		t_compat();
		t_prio();
		t_gate();
		t_pins();
		t_port();
		t_race();
		stop_test();
	end

	// Whole run is a few hundred cycles; allow about fifteen times that
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
endmodule
`default_nettype wire
